// ### common/ofd_pkg.sv
// package for the operand field decoder: field layouts, codes, constants
// assumes nothing beyond a systemverilog compiler
package ofd_pkg;
  localparam logic [1:0] MODE_NO_DISP = 2'h0;
  localparam logic [1:0] MODE_DISP8 = 2'h1;
  localparam logic [1:0] MODE_DISP16 = 2'h2;
  localparam logic [1:0] MODE_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  localparam logic [2:0] PFX_HEAD = 3'h1;
  localparam logic [2:0] PFX_TAIL = 3'h6;
  // register file indices (word view)
  localparam logic [2:0] R_ACC = 3'h0;
  localparam logic [2:0] R_CNT = 3'h1;
  localparam logic [2:0] R_DAT = 3'h2;
  localparam logic [2:0] R_BAS = 3'h3;
  localparam logic [2:0] R_STK = 3'h4;
  localparam logic [2:0] R_FRM = 3'h5;
  localparam logic [2:0] R_SRC = 3'h6;
  localparam logic [2:0] R_DST = 3'h7;
  // status word bit positions
  localparam int SW_OVF = 11;
  localparam int SW_DIR = 10;
  localparam int SW_IEN = 9;
  localparam int SW_STEP = 8;
  localparam int SW_SIGN = 7;
  localparam int SW_ZERO = 6;
  localparam int SW_AUX = 4;
  localparam int SW_PAR = 2;
  localparam int SW_CARRY = 0;
  localparam logic [15:0] SW_MASK = 16'h0fd5;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  typedef struct packed {
    logic       dir;
    logic       wide;
    logic       sext;
    logic       cnt_src;
    logic       rep_zero;
    logic       has_imm;
    logic       is_seg_move;
  } ofd_ctl_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_MODRM = 5'b00010,
    ST_DISP = 5'b00100,
    ST_IMM = 5'b01000,
    ST_DONE = 5'b10000
  } ofd_state_t;
  typedef struct packed {
    logic [15:0] loc;
    logic [15:0] imm;
    logic [2:0]  reg_sel;
    logic [2:0]  rm_sel;
    logic        rm_is_reg;
    logic        reg_is_dst;
    logic        wide;
    logic [1:0]  seg;
    logic        seg_forced;
    logic        illegal;
  } ofd_result_t;
endpackage

// ### verification/ofd_decoder_tb.sv
// self-checking bench for the operand field decoder
// assumes the fetch model on the byte side; clk_en held high
`timescale 1ns/100ps
module ofd_decoder_tb;
  import ofd_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic start = 1'b0;
  logic status_we = 1'b0;
  logic load = 1'b0;
  logic slow = 1'b0;
  logic byte_valid, byte_ready, cond_true, rep_continue, done;
  logic [7:0] byte_data, shift_count;
  logic [15:0] status_wdata = 16'h0000;
  logic [15:0] status_word, reg_operand;
  logic [3:0] cond_sel = 4'h0;
  logic [63:0] load_bytes = 64'h0;
  logic [3:0] load_len = 4'h0;
  logic [127:0] regs_flat;
  ofd_ctl_t ctl = '0;
  ofd_result_t result;
  int fails = 0;
  int checks = 0;
  logic [15:0] rv [8] = '{16'h1122, 16'h3305, 16'h5566, 16'h4077,
                          16'h8899, 16'h6000, 16'h0700, 16'h0080};
  logic [15:0] fl [5] = '{16'h0001, 16'h0080, 16'h0880, 16'h0840, 16'h0004};
  assign regs_flat = {rv[7], rv[6], rv[5], rv[4], rv[3], rv[2], rv[1], rv[0]};
  always #5 clk_sys = ~clk_sys;
  ofd_decoder u_ofd_decoder (.clk_sys, .srst, .clk_en, .byte_valid,
    .byte_data, .byte_ready, .start, .ctl, .regs_flat, .status_wdata,
    .status_we, .status_word, .cond_sel, .cond_true, .rep_continue,
    .shift_count, .reg_operand, .done, .result);
  ofd_fetch_model u_ofd_fetch_model (.clk_sys, .srst, .load, .load_bytes,
    .load_len, .slow, .byte_ready, .byte_valid, .byte_data);
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one decode: start with ctl, feed n bytes, wait for done
  task automatic dec(logic [6:0] c, logic [63:0] b, logic [3:0] n);
    int k;
    @(posedge clk_sys);
    ctl <= ofd_ctl_t'(c);
    start <= 1'b1;
    load <= 1'b1;
    load_bytes <= b;
    load_len <= n;
    @(posedge clk_sys);
    start <= 1'b0;
    load <= 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk_sys);
    if (done !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic wsw(logic [15:0] v);
    @(posedge clk_sys);
    status_wdata <= v;
    status_we <= 1'b1;
    @(posedge clk_sys);
    status_we <= 1'b0;
    @(negedge clk_sys);
  endtask
  function automatic logic [15:0] ea(logic [2:0] m);
    case (m)
      3'h0: return rv[3] + rv[6];
      3'h1: return rv[3] + rv[7];
      3'h2: return rv[5] + rv[6];
      3'h3: return rv[5] + rv[7];
      3'h4: return rv[6];
      3'h5: return rv[7];
      3'h6: return rv[5];
      default: return rv[3];
    endcase
  endfunction
  function automatic logic cexp(logic [15:0] f, logic [3:0] s);
    logic o, c, z, g;
    o = f[11];
    c = f[0];
    z = f[6];
    g = f[7];
    case (s[3:1])
      3'h0: return o ^ s[0];
      3'h1: return c ^ s[0];
      3'h2: return z ^ s[0];
      3'h3: return (c | z) ^ s[0];
      3'h4: return g ^ s[0];
      3'h5: return f[2] ^ s[0];
      3'h6: return (g ^ o) ^ s[0];
      default: return ((g ^ o) | z) ^ s[0];
    endcase
  endfunction
  initial begin
    int i;
    int k;
    logic [15:0] e;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    chk("status reset", status_word, 16'h0000);
    wsw(16'hffff);
    chk("status mask", status_word, 16'h0fd5);
    for (i = 0; i < 5; i++) begin
      wsw(fl[i]);
      for (k = 0; k < 16; k++) begin
        @(posedge clk_sys);
        cond_sel <= 4'(k);
        @(negedge clk_sys);
        chk("cond", 16'(cond_true), 16'(cexp(fl[i], 4'(k))));
      end
    end
    for (i = 0; i < 8; i++) begin
      dec(7'h60, {48'h0, 8'h80, 2'h1, 3'h2, 3'(i)}, 4'h2);
      chk("loc d8", result.loc, ea(3'(i)) + 16'hff80);
      chk("dst", 16'(result.reg_is_dst), 16'h1);
      chk("mem", 16'(result.rm_is_reg), 16'h0);
    end
    dec(7'h22, 64'hab_cd_12_34_86, 4'h5);
    chk("loc d16", result.loc, 16'h7234);
    chk("imm word", result.imm, 16'habcd);
    chk("src", 16'(result.reg_is_dst), 16'h0);
    dec(7'h32, 64'h85_56_78_06, 4'h4);
    chk("loc direct", result.loc, 16'h5678);
    chk("imm sext", result.imm, 16'hff85);
    slow <= 1'b1;
    dec(7'h32, 64'h22_00, 4'h2);
    chk("loc d0", result.loc, ea(3'h0));
    chk("imm after", result.imm, 16'h0022);
    slow <= 1'b0;
    for (i = 0; i < 16; i++) begin
      k = i % 8;
      dec({1'b1, i[3], 5'h0}, {56'h0, 2'h3, 3'(k), 3'(7 - k)}, 4'h1);
      chk("rm reg", 16'(result.rm_sel), 16'(7 - k));
      chk("rm flag", 16'(result.rm_is_reg), 16'h1);
      chk("reg sel", 16'(result.reg_sel), 16'(k));
      chk("wide", 16'(result.wide), 16'(i[3]));
      e = k < 4 ? rv[k] : rv[k - 4] >> 8;
      if (i[3]) chk("word", reg_operand, rv[k]);
      else chk("byte", 16'(reg_operand[7:0]), 16'(e[7:0]));
    end
    for (i = 0; i < 4; i++) begin
      dec(7'h20, {48'h0, 8'h00, 3'h1, 2'(i), 3'h6}, 4'h2);
      chk("seg", 16'(result.seg), 16'(i));
      chk("forced", 16'(result.seg_forced), 16'h1);
    end
    for (i = 0; i < 2; i++) begin
      dec(7'h61, {56'h0, 2'h3, 1'b0, i[0], 1'b1, 3'h0}, 4'h1);
      chk("illegal", 16'(result.illegal), 16'(i == 0));
    end
    for (i = 0; i < 4; i++) begin
      wsw(i[0] ? 16'h0040 : 16'h0000);
      dec({3'h2, i[1], i[1], 2'h0}, 64'hc0, 4'h1);
      chk("repeat", 16'(rep_continue), 16'(i[0] == i[1]));
      e = i[1] ? 16'(rv[1][7:0]) : 16'h1;
      chk("count", 16'(shift_count), e);
    end
    report_and_stop();
  end
endmodule

// ### verification/ofd_fetch_model.sv
// fetch queue stand-in: hands a loaded byte string to the decoder
// assumes load pulses on the same edge that the decoder takes start
`timescale 1ns/100ps
module ofd_fetch_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [63:0] load_bytes,
  input wire logic [3:0] load_len,
  input wire logic slow,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [63:0] buf_q;
  logic [3:0] len_q;
  logic [3:0] pos_q;
  logic [7:0] last_q;
  // an idle line shows the inverse of the last byte, never a stale copy
  assign byte_data = byte_valid ? buf_q[pos_q*8+:8] : ~last_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      byte_valid <= 1'b0;
      len_q <= 4'h0;
      pos_q <= 4'h0;
      last_q <= 8'h00;
    end else if (load) begin
      buf_q <= load_bytes;
      len_q <= load_len;
      pos_q <= 4'h0;
      byte_valid <= !slow;
    end else if (byte_valid && byte_ready) begin
      last_q <= byte_data;
      pos_q <= pos_q + 4'h1;
      byte_valid <= !slow && (pos_q + 4'h1 < len_q);
    end else begin
      byte_valid <= pos_q < len_q;
    end
  end
endmodule

// ### verilog/ofd_decoder.sv
// operand field decoder: walks operand bytes, forms operand location
// assumes byte stream from fetch queue, one byte per valid cycle
// Notes on behaviour
// - sext/width 01 takes two immediate bytes; 11 takes one sign-extended
// - shift count is one when source bit 0, else count low byte
// - repeat continues while zero bit equals repeat-condition bit
// - direction 1 makes reg field the destination, 0 the source
// - width 1 word operation, width 0 byte operation
// - mode 11 treats r/m as register number, no memory operand
// - mode 00 has zero displacement and no displacement bytes, except direct
// - mode 01 takes one displacement byte, sign-extended
// - mode 10 takes two displacement bytes, low first
// - r/m 000-011 use base/frame plus source/destination index
// - r/m 100-111 use source, destination, frame, base alone
// - mode 00 r/m 110 uses two bytes as direct address
// - displacement bytes come right after modrm, before immediate
// - register codes map word regs or low then high byte halves
// - prefix 001 seg 110 overrides segment: extra, code, stack, data
// - status word bit layout, other bits read zero
// - move to code segment register is flagged illegal
// - above/below unsigned, greater/less signed comparisons
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ofd_decoder
  import ofd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  input wire logic start,
  input wire ofd_ctl_t ctl,
  input wire logic [127:0] regs_flat,
  input wire logic [15:0] status_wdata,
  input wire logic status_we,
  output logic [15:0] status_word,
  input wire logic [3:0] cond_sel,
  output logic cond_true,
  output logic rep_continue,
  output logic [7:0] shift_count,
  output logic [15:0] reg_operand,
  output logic done,
  output ofd_result_t result
);
  ofd_state_t state_q;
  logic [15:0] regs [8];
  logic [1:0] mode_q;
  logic [2:0] reg_q, rm_q;
  logic [15:0] disp_q, imm_q;
  logic [1:0] dcnt_q, icnt_q;
  logic [1:0] seg_q;
  logic seg_forced_q;
  logic [15:0] status_q;
  ofd_ctl_t ctl_q;
  logic [1:0] disp_need, imm_need;
  logic take;
  logic [15:0] base_sum;
  logic [15:0] loc_d;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      regs[i] = regs_flat[i*16 +: 16];
    end
  end

  // ready only while a byte is owed, so none is popped and dropped
  always_comb begin
    byte_ready = 1'b0;
    if (clk_en && !srst) begin
      if (state_q == ST_MODRM) begin
        byte_ready = 1'b1;
      end else if (state_q == ST_DISP) begin
        byte_ready = (dcnt_q != disp_need);
      end else if (state_q == ST_IMM) begin
        byte_ready = (icnt_q != imm_need);
      end
    end
  end

  assign take = byte_ready && byte_valid;
  assign done = (state_q == ST_DONE);

  // displacement byte count from mode
  always_comb begin
    disp_need = 2'h0;
    if (mode_q == MODE_DISP8) begin
      disp_need = 2'h1;
    end else if (mode_q == MODE_DISP16) begin
      disp_need = 2'h2;
    end else if (mode_q == MODE_NO_DISP && rm_q == RM_DIRECT) begin
      disp_need = 2'h2;
    end else begin
      disp_need = 2'h0;
    end
  end

  // immediate byte count
  always_comb begin
    imm_need = 2'h0;
    if (ctl_q.has_imm) begin
      if (ctl_q.wide && !ctl_q.sext) begin
        imm_need = 2'h2;
      end else begin
        imm_need = 2'h1;
      end
    end
  end

  // byte walk: prefix, modrm, displacement, then immediate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
      mode_q <= 2'h0;
      reg_q <= 3'h0;
      rm_q <= 3'h0;
      disp_q <= 16'h0000;
      imm_q <= 16'h0000;
      dcnt_q <= 2'h0;
      icnt_q <= 2'h0;
      seg_q <= SEG_DATA;
      seg_forced_q <= 1'b0;
      ctl_q <= '0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            ctl_q <= ctl;
            seg_forced_q <= 1'b0;
            disp_q <= 16'h0000;
            imm_q <= 16'h0000;
            dcnt_q <= 2'h0;
            icnt_q <= 2'h0;
            state_q <= ST_MODRM;
          end
        end
        ST_MODRM: begin
          if (take) begin
            if (byte_data[7:5] == PFX_HEAD && byte_data[2:0] == PFX_TAIL) begin
              seg_q <= byte_data[4:3];
              seg_forced_q <= 1'b1;
            end else begin
              mode_q <= byte_data[7:6];
              reg_q <= byte_data[5:3];
              rm_q <= byte_data[2:0];
              state_q <= ST_DISP;
            end
          end
        end
        ST_DISP: begin
          if (dcnt_q == disp_need) begin
            state_q <= (imm_need == 2'h0) ? ST_DONE : ST_IMM;
          end else if (take) begin
            if (dcnt_q == 2'h0) begin
              disp_q <= {{8{byte_data[7]}}, byte_data};
            end else begin
              disp_q[15:8] <= byte_data;
            end
            dcnt_q <= dcnt_q + 2'h1;
          end
        end
        ST_IMM: begin
          if (icnt_q == imm_need) begin
            state_q <= ST_DONE;
          end else if (take) begin
            if (icnt_q == 2'h0) begin
              imm_q <= {{8{byte_data[7]}}, byte_data};
            end else begin
              imm_q[15:8] <= byte_data;
            end
            icnt_q <= icnt_q + 2'h1;
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // operand location from r/m code
  always_comb begin
    base_sum = 16'h0000;
    case (rm_q)
      3'h0: base_sum = regs[R_BAS] + regs[R_SRC];
      3'h1: base_sum = regs[R_BAS] + regs[R_DST];
      3'h2: base_sum = regs[R_FRM] + regs[R_SRC];
      3'h3: base_sum = regs[R_FRM] + regs[R_DST];
      3'h4: base_sum = regs[R_SRC];
      3'h5: base_sum = regs[R_DST];
      3'h6: base_sum = regs[R_FRM];
      default: base_sum = regs[R_BAS];
    endcase
    if (mode_q == MODE_NO_DISP && rm_q == RM_DIRECT) begin
      loc_d = disp_q;
    end else begin
      loc_d = base_sum + disp_q;
    end
  end

  // byte or word register read
  function automatic logic [15:0] rd_reg(input logic [2:0] code,
                                         input logic wide);
    logic [15:0] w;
    w = regs[{1'b0, code[1:0]}];
    if (wide) begin
      rd_reg = regs[code];
    end else if (code[2]) begin
      rd_reg = {8'h00, w[15:8]};
    end else begin
      rd_reg = {8'h00, w[7:0]};
    end
  endfunction

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result <= '0;
      reg_operand <= 16'h0000;
    end else if (clk_en && state_q == ST_DISP && dcnt_q == disp_need) begin
      result.loc <= loc_d;
      result.rm_sel <= rm_q;
      result.reg_sel <= reg_q;
      result.rm_is_reg <= (mode_q == MODE_REG);
      result.reg_is_dst <= ctl_q.dir;
      result.wide <= ctl_q.wide;
      result.seg <= seg_forced_q ? seg_q :
                    ((rm_q == 3'h2 || rm_q == 3'h3 ||
                     (rm_q == RM_DIRECT && mode_q != MODE_NO_DISP)) ?
                     SEG_STACK : SEG_DATA);
      result.seg_forced <= seg_forced_q;
      result.illegal <= ctl_q.is_seg_move && ctl_q.dir &&
                        reg_q[1:0] == SEG_CODE;
      reg_operand <= rd_reg(reg_q, ctl_q.wide);
      result.imm <= 16'h0000;
    end else if (clk_en && state_q == ST_IMM && icnt_q == imm_need) begin
      result.imm <= imm_q;
    end
  end

  // status word, unused bits forced to zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= SW_RESET;
    end else if (clk_en && status_we) begin
      status_q <= status_wdata & SW_MASK;
    end
  end
  assign status_word = status_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_count <= COUNT_ONE;
      rep_continue <= 1'b0;
    end else if (clk_en) begin
      shift_count <= ctl_q.cnt_src ? regs[R_CNT][7:0] : COUNT_ONE;
      rep_continue <= (status_q[SW_ZERO] == ctl_q.rep_zero);
    end
  end

  // branch condition, unsigned above/below and signed greater/less
  logic cf, zf, sf, of_b, pf;
  assign cf = status_q[SW_CARRY];
  assign zf = status_q[SW_ZERO];
  assign sf = status_q[SW_SIGN];
  assign of_b = status_q[SW_OVF];
  assign pf = status_q[SW_PAR];
  always_comb begin
    logic c;
    c = 1'b0;
    case (cond_sel[3:1])
      3'h0: c = of_b;
      3'h1: c = cf;
      3'h2: c = zf;
      3'h3: c = cf | zf;
      3'h4: c = sf;
      3'h5: c = pf;
      3'h6: c = sf ^ of_b;
      default: c = (sf ^ of_b) | zf;
    endcase
    cond_true = c ^ cond_sel[0];
  end

  chk_sext_byte: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_IMM && icnt_q == 2'h1 && imm_need == 2'h1)
    |-> imm_q[15:8] == {8{imm_q[7]}})
    else $error("sign extension of immediate wrong");
  chk_shift_one: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && !ctl_q.cnt_src) |=> shift_count == COUNT_ONE)
    else $error("shift count not one");
  chk_direct_loc: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_DISP && dcnt_q == disp_need &&
     mode_q == MODE_NO_DISP && rm_q == RM_DIRECT)
    |=> result.loc == $past(disp_q))
    else $error("direct address wrong");
  chk_no_disp: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && mode_q == MODE_REG) |-> dcnt_q == 2'h0)
    else $error("register mode took displacement");
  chk_disp8_one: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && mode_q == MODE_DISP8) |-> dcnt_q <= 2'h1)
    else $error("too many displacement bytes");
  chk_mode0_none: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && mode_q == MODE_NO_DISP && rm_q != RM_DIRECT)
    |-> dcnt_q == 2'h0 && disp_q == 16'h0000)
    else $error("mode zero displacement not zero");
  chk_status_mask: assert property (@(posedge clk_sys)
    disable iff (srst)
    (status_word & ~SW_MASK) == 16'h0000)
    else $error("reserved status bits set");
  chk_imm_after: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_IMM) |-> dcnt_q == disp_need)
    else $error("immediate before displacement");
  chk_rep_cond: assert property (@(posedge clk_sys)
    disable iff (srst)
    clk_en |=> rep_continue == ($past(status_q[SW_ZERO]) ==
                                $past(ctl_q.rep_zero)))
    else $error("repeat decision wrong");
  chk_ready_owed: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && dcnt_q == disp_need) |-> !byte_ready)
    else $error("ready raised with no byte owed");
  chk_ready_done: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DONE || state_q == ST_IDLE) |-> !byte_ready)
    else $error("ready raised outside a decode");
  chk_disp16_two: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && mode_q == MODE_DISP16) |-> dcnt_q <= 2'h2)
    else $error("too many word displacement bytes");
  chk_disp8_sext: assert property (@(posedge clk_sys)
    disable iff (srst)
    (state_q == ST_DISP && mode_q == MODE_DISP8 && dcnt_q == 2'h1)
    |-> disp_q[15:8] == {8{disp_q[7]}})
    else $error("byte displacement not sign-extended");
  chk_disp_low: assert property (@(posedge clk_sys)
    disable iff (srst)
    (take && state_q == ST_DISP && dcnt_q == 2'h0)
    |=> disp_q[7:0] == $past(byte_data))
    else $error("displacement low byte lost");
  chk_disp_high: assert property (@(posedge clk_sys)
    disable iff (srst)
    (take && state_q == ST_DISP && dcnt_q == 2'h1)
    |=> disp_q[15:8] == $past(byte_data))
    else $error("displacement high byte lost");
  chk_imm_low: assert property (@(posedge clk_sys)
    disable iff (srst)
    (take && state_q == ST_IMM && icnt_q == 2'h0)
    |=> imm_q[7:0] == $past(byte_data))
    else $error("immediate low byte lost");
  chk_reg_mode: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_DISP && dcnt_q == disp_need)
    |=> result.rm_is_reg == ($past(mode_q) == MODE_REG))
    else $error("register mode flag wrong");
  chk_dir_field: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_DISP && dcnt_q == disp_need)
    |=> result.reg_is_dst == $past(ctl_q.dir))
    else $error("direction of register field wrong");
  chk_width_sel: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_DISP && dcnt_q == disp_need)
    |=> result.wide == $past(ctl_q.wide))
    else $error("operand width wrong");
  chk_code_seg: assert property (@(posedge clk_sys)
    disable iff (srst)
    (clk_en && state_q == ST_DISP && dcnt_q == disp_need &&
     ctl_q.is_seg_move && ctl_q.dir && reg_q[1:0] == SEG_CODE)
    |=> result.illegal)
    else $error("move to code segment not flagged");
  chk_seg_prefix: assert property (@(posedge clk_sys)
    disable iff (srst)
    (take && state_q == ST_MODRM && byte_data[7:5] == PFX_HEAD &&
     byte_data[2:0] == PFX_TAIL) |=> seg_forced_q)
    else $error("segment prefix not seen");
endmodule
